// >>> lpc_pkg.sv
/*
 package for the flash cycle-acceptance block and its host end.
 assumes both ends share one clock and reset.
 */
`default_nettype none
package lpc_pkg;
	// -------------------------------
	// field codes
	// -------------------------------
	localparam logic [3:0] START_LPC = 4'h0;
	localparam logic [3:0] START_FWR = 4'hd;
	localparam logic [3:0] START_FWW = 4'he;
	localparam logic [1:0] TYPE_MEM = 2'h1;
	localparam logic [3:0] MSIZE_ONE = 4'h0;
	localparam logic [3:0] SYNC_OK = 4'h0;
	localparam logic [3:0] NIB_ONES = 4'hf;
	localparam int TYPE_WR_BIT = 1;
	localparam int ARRAY_BIT = 22;
	localparam logic [2:0] LPC_ADDR_LAST = 3'h7;
	localparam logic [2:0] FW_ADDR_LAST = 3'h6;
	// -------------------------------
	// address windows
	// -------------------------------
	localparam logic [8:0] HI_WIN = 9'h1ff;
	localparam logic [14:0] LO_WIN = 15'h0007;
	// -------------------------------
	// timing
	// -------------------------------
	localparam int CLK_NS = 50;
	localparam int SETTLE_NS = 1000;
	localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int SYNC_TMO = 8;
	localparam int POLL_STABLE = 2;

	function automatic logic in_range(input logic [31:0] a);
		in_range = (a[31:23] == HI_WIN) || (a[31:17] == LO_WIN);
	endfunction

	function automatic logic [3:0] addr_id(input logic [31:0] a);
		addr_id = {a[23], a[21:19]};
	endfunction
endpackage
`default_nettype wire

// >>> lpc_link_if.sv
/*
 the shared lpc link: frame strobe and the four-bit multiplexed lines.
 assumes an external pull-up, modelled here as ones when nobody drives.
 */
`timescale 1ns/100ps
`default_nettype none
interface lpc_link_if;
	logic lframe_n;
	logic [3:0] h_out;
	logic h_oe;
	logic [3:0] d_out;
	logic d_oe;
	logic [3:0] lad;

	assign lad = h_oe ? h_out : (d_oe ? d_out : 4'hf);

	modport host (output lframe_n, output h_out, output h_oe, input lad);
	modport dev (input lframe_n, input lad, output d_out, output d_oe);
endinterface
`default_nettype wire

// >>> lpc_flash_dev.sv
/*
 device end: decodes lpc memory and firmware memory cycles, checks the
 strap select (and the address window for lpc memory cycles only), hands accepted
 accesses to the user side and folds write-status bits into reads.
 assumes the user side returns rd_data in the cycle after acc_valid.
 */
`timescale 1ns/100ps
`default_nettype none
module lpc_flash_dev #(
	parameter int SETTLE_CYC = lpc_pkg::SETTLE_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// link
	lpc_link_if.dev link,
	// select straps
	input wire logic [3:0] select_strap_pins,
	// internal write engine state
	input wire logic op_busy,
	input wire logic op_erase,
	input wire logic [7:0] op_data,
	// access to array or registers
	output logic acc_valid,
	output logic acc_write,
	output logic acc_array,
	output logic [18:0] acc_addr,
	output logic [7:0] acc_wdata,
	input wire logic [7:0] rd_data
);
	typedef enum logic [3:0] {
		S_IDLE = 4'h0,
		S_TYPE = 4'h1,
		S_FW_DEVICE_SELECT_FIELD = 4'h3,
		S_ADDR = 4'h2,
		S_MSIZE = 4'h6,
		S_WD0 = 4'h7,
		S_WD1 = 4'h5,
		S_TAR0 = 4'h4,
		S_TAR1 = 4'hc,
		S_SYNC = 4'hd,
		S_RD0 = 4'hf,
		S_RD1 = 4'he,
		S_ETAR = 4'ha,
		S_SKIP = 4'hb
	} dstate_t;

	generate
		if (SETTLE_CYC < 1 || SETTLE_CYC > 255) begin : g_chk
			$error("SETTLE_CYC out of range");
		end
	endgenerate

	dstate_t st_reg;
	logic fw_reg;
	logic wr_reg;
	logic [2:0] nib_reg;
	logic [31:0] addr_reg;
	logic [31:0] addr_next;
	logic [7:0] wd_reg;
	logic [7:0] rdq_reg;
	logic [3:0] out_reg;
	logic oe_reg;
	logic accept;
	logic erase_reg;
	logic busy_prev_reg;
	logic tog_reg;
	logic [7:0] settle_reg;
	logic [7:0] merged;

	assign link.d_out = out_reg;
	assign link.d_oe = oe_reg;
	assign addr_next = {addr_reg[27:0], link.lad};

	// -------------------------------
	// acceptance decision
	// -------------------------------
	always_comb begin
		accept = 1'b0;
		if (link.lframe_n && st_reg == S_ADDR && nib_reg == 3'h0 && !fw_reg) begin
			accept = lpc_pkg::in_range(addr_next)
				&& (lpc_pkg::addr_id(addr_next) == ~select_strap_pins);
		end else if (link.lframe_n && st_reg == S_MSIZE) begin
			accept = (link.lad == lpc_pkg::MSIZE_ONE);
		end
	end

	// -------------------------------
	// field sequencer and line drive
	// -------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= S_IDLE;
			fw_reg <= 1'b0;
			wr_reg <= 1'b0;
			nib_reg <= 3'h0;
			addr_reg <= 32'h0000_0000;
			wd_reg <= 8'h00;
			out_reg <= 4'hf;
			oe_reg <= 1'b0;
		end else if (!link.lframe_n) begin
			// a low frame restarts decoding, which also covers abort
			oe_reg <= 1'b0;
			wr_reg <= (link.lad == lpc_pkg::START_FWW);
			if (link.lad == lpc_pkg::START_LPC) begin
				fw_reg <= 1'b0;
				st_reg <= S_TYPE;
			end else if (link.lad == lpc_pkg::START_FWR || link.lad == lpc_pkg::START_FWW) begin
				fw_reg <= 1'b1;
				st_reg <= S_FW_DEVICE_SELECT_FIELD;
			end else begin
				st_reg <= S_IDLE;
			end
		end else begin
			case (st_reg)
				S_TYPE: begin
					if (link.lad[3:2] == lpc_pkg::TYPE_MEM) begin
						wr_reg <= link.lad[lpc_pkg::TYPE_WR_BIT];
						nib_reg <= lpc_pkg::LPC_ADDR_LAST;
						st_reg <= S_ADDR;
					end else begin
						st_reg <= S_SKIP;
					end
				end
				S_FW_DEVICE_SELECT_FIELD: begin
					// any of the sixteen strap values selects its own device
					if (link.lad == select_strap_pins) begin
						nib_reg <= lpc_pkg::FW_ADDR_LAST;
						st_reg <= S_ADDR;
					end else begin
						st_reg <= S_SKIP;
					end
				end
				S_ADDR: begin
					addr_reg <= addr_next;
					nib_reg <= nib_reg - 3'h1;
					if (nib_reg == 3'h0) begin
						if (fw_reg) begin
							st_reg <= S_MSIZE;
						end else if (accept) begin
							st_reg <= wr_reg ? S_WD0 : S_TAR0;
						end else begin
							st_reg <= S_SKIP;
						end
					end
				end
				S_MSIZE: begin
					if (accept) begin
						st_reg <= wr_reg ? S_WD0 : S_TAR0;
					end else begin
						st_reg <= S_SKIP;
					end
				end
				S_WD0: begin
					wd_reg[3:0] <= link.lad;
					st_reg <= S_WD1;
				end
				S_WD1: begin
					wd_reg[7:4] <= link.lad;
					st_reg <= S_TAR0;
				end
				S_TAR0: begin
					st_reg <= S_TAR1;
				end
				S_TAR1: begin
					// sync is sent even while busy; only the write is dropped
					out_reg <= lpc_pkg::SYNC_OK;
					oe_reg <= 1'b1;
					st_reg <= S_SYNC;
				end
				S_SYNC: begin
					out_reg <= wr_reg ? lpc_pkg::NIB_ONES : rdq_reg[3:0];
					st_reg <= wr_reg ? S_ETAR : S_RD0;
				end
				S_RD0: begin
					out_reg <= rdq_reg[7:4];
					st_reg <= S_RD1;
				end
				S_RD1: begin
					out_reg <= lpc_pkg::NIB_ONES;
					st_reg <= S_ETAR;
				end
				S_ETAR: begin
					oe_reg <= 1'b0;
					st_reg <= S_IDLE;
				end
				default: begin
					oe_reg <= 1'b0;
					st_reg <= st_reg;
				end
			endcase
		end
	end

	// -------------------------------
	// user-side access strobe
	// -------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			acc_valid <= 1'b0;
			acc_write <= 1'b0;
			acc_array <= 1'b0;
			acc_addr <= 19'h00000;
			acc_wdata <= 8'h00;
		end else begin
			acc_valid <= 1'b0;
			if (accept && !wr_reg) begin
				acc_valid <= 1'b1;
				acc_write <= 1'b0;
				acc_array <= (st_reg == S_ADDR) ? addr_next[lpc_pkg::ARRAY_BIT]
					: addr_reg[lpc_pkg::ARRAY_BIT];
				acc_addr <= (st_reg == S_ADDR) ? addr_next[18:0] : addr_reg[18:0];
			end else if (link.lframe_n && st_reg == S_WD1 && !op_busy) begin
				acc_valid <= 1'b1;
				acc_write <= 1'b1;
				acc_array <= addr_reg[lpc_pkg::ARRAY_BIT];
				acc_addr <= addr_reg[18:0];
				acc_wdata <= {link.lad, wd_reg[3:0]};
			end
		end
	end

	// -------------------------------
	// write status folded into reads
	// -------------------------------
	always_comb begin
		if (op_busy) begin
			merged = {op_erase ? 1'b0 : ~op_data[7], tog_reg, rd_data[5:0]};
		end else if (settle_reg != 8'h00) begin
			// only bit 7 is trusted until the array output settles
			merged = {rd_data[7] | erase_reg, tog_reg, 6'h00};
		end else begin
			merged = rd_data;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdq_reg <= 8'h00;
			tog_reg <= 1'b0;
		end else if (link.lframe_n && st_reg == S_TAR1 && !wr_reg) begin
			rdq_reg <= merged;
			if (op_busy) begin
				tog_reg <= ~tog_reg;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			busy_prev_reg <= 1'b0;
			erase_reg <= 1'b0;
			settle_reg <= 8'h00;
		end else begin
			busy_prev_reg <= op_busy;
			if (op_busy) begin
				erase_reg <= op_erase;
				settle_reg <= 8'h00;
			end else if (busy_prev_reg) begin
				settle_reg <= 8'(SETTLE_CYC);
			end else if (settle_reg != 8'h00) begin
				settle_reg <= settle_reg - 8'h01;
			end
		end
	end
endmodule // lpc_flash_dev
`default_nettype wire

// >>> lpc_flash_host.sv
/*
 host end: runs one lpc memory or firmware memory byte cycle per plain command, repeats it for a poll,
 aborts when no sync arrives, and can poll a location for write completion.
 assumes one device end on the link and the shared clock.
 */
`timescale 1ns/100ps
`default_nettype none
module lpc_flash_host #(
	parameter int SYNC_TMO = lpc_pkg::SYNC_TMO
) (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// link
	lpc_link_if.host link,
	// command port
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic cmd_fw,
	input wire logic cmd_poll,
	input wire logic [3:0] cmd_fw_device_select_field,
	input wire logic [31:0] cmd_addr,
	input wire logic [7:0] cmd_wdata,
	output logic cmd_ready,
	output logic done,
	output logic ok,
	output logic [7:0] rdata
);
	typedef enum logic [3:0] {
		H_IDLE = 4'h0,
		H_START = 4'h1,
		H_TYPE = 4'h3,
		H_ADDR = 4'h2,
		H_MSIZE = 4'h6,
		H_WD = 4'h7,
		H_TAR0 = 4'h5,
		H_TAR1 = 4'h4,
		H_WAIT = 4'hc,
		H_RD = 4'hd,
		H_ETAR = 4'hf,
		H_GAP = 4'he,
		H_ABORT = 4'ha
	} hstate_t;

	generate
		if (SYNC_TMO < 1 || SYNC_TMO > 255) begin : g_chk
			$error("SYNC_TMO out of range");
		end
	endgenerate

	hstate_t st_reg;
	logic lframe_reg;
	logic [3:0] out_reg;
	logic oe_reg;
	logic wr_reg;
	logic fw_reg;
	logic poll_reg;
	logic again_reg;
	logic ph_reg;
	logic [2:0] nib_reg;
	logic [31:0] a_reg;
	logic [7:0] wd_reg;
	logic [7:0] wcnt_reg;
	logic [1:0] stable_reg;
	logic have_reg;
	logic [3:0] fw_device_select_field_reg;

	assign link.lframe_n = lframe_reg;
	assign link.h_out = out_reg;
	assign link.h_oe = oe_reg;

	function automatic logic [3:0] nib_of(input logic [31:0] a, input logic [2:0] n);
		nib_of = a[{n, 2'b00} +: 4];
	endfunction

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= H_IDLE;
			lframe_reg <= 1'b1;
			out_reg <= 4'hf;
			oe_reg <= 1'b0;
			wr_reg <= 1'b0;
			fw_reg <= 1'b0;
			poll_reg <= 1'b0;
			again_reg <= 1'b0;
			ph_reg <= 1'b0;
			nib_reg <= 3'h0;
			a_reg <= 32'h0000_0000;
			wd_reg <= 8'h00;
			wcnt_reg <= 8'h00;
			fw_device_select_field_reg <= 4'h0;
			cmd_ready <= 1'b1;
			done <= 1'b0;
			ok <= 1'b0;
			rdata <= 8'h00;
		end else begin
			done <= 1'b0;
			case (st_reg)
				H_IDLE: begin
					if (again_reg || cmd_valid) begin
						if (!again_reg) begin
							wr_reg <= cmd_write;
							fw_reg <= cmd_fw;
							poll_reg <= cmd_poll && !cmd_write;
							a_reg <= cmd_addr;
							wd_reg <= cmd_wdata;
							fw_device_select_field_reg <= cmd_fw_device_select_field;
						end
						cmd_ready <= 1'b0;
						again_reg <= 1'b0;
						if (!again_reg && cmd_poll && !cmd_fw && !lpc_pkg::in_range(cmd_addr)) begin
							done <= 1'b1;
							ok <= 1'b0;
							cmd_ready <= 1'b1;
						end else begin
							lframe_reg <= 1'b0;
							oe_reg <= 1'b1;
							if (again_reg ? fw_reg : cmd_fw) begin
								out_reg <= (again_reg ? wr_reg : cmd_write)
									? lpc_pkg::START_FWW : lpc_pkg::START_FWR;
							end else begin
								out_reg <= lpc_pkg::START_LPC;
							end
							st_reg <= H_START;
						end
					end
				end
				H_START: begin
					lframe_reg <= 1'b1;
					if (fw_reg) begin
						out_reg <= fw_device_select_field_reg;
						nib_reg <= lpc_pkg::FW_ADDR_LAST;
					end else begin
						out_reg <= {lpc_pkg::TYPE_MEM, wr_reg, 1'b0};
						nib_reg <= lpc_pkg::LPC_ADDR_LAST;
					end
					st_reg <= H_TYPE;
				end
				H_TYPE: begin
					out_reg <= nib_of(a_reg, nib_reg);
					st_reg <= H_ADDR;
				end
				H_ADDR, H_MSIZE: begin
					if (st_reg == H_ADDR && nib_reg != 3'h0) begin
						nib_reg <= nib_reg - 3'h1;
						out_reg <= nib_of(a_reg, nib_reg - 3'h1);
					end else if (st_reg == H_ADDR && fw_reg) begin
						out_reg <= lpc_pkg::MSIZE_ONE;
						st_reg <= H_MSIZE;
					end else if (wr_reg) begin
						out_reg <= wd_reg[3:0];
						ph_reg <= 1'b0;
						st_reg <= H_WD;
					end else begin
						out_reg <= lpc_pkg::NIB_ONES;
						st_reg <= H_TAR0;
					end
				end
				H_WD: begin
					ph_reg <= 1'b1;
					out_reg <= ph_reg ? lpc_pkg::NIB_ONES : wd_reg[7:4];
					st_reg <= ph_reg ? H_TAR0 : H_WD;
				end
				H_TAR0: begin
					oe_reg <= 1'b0;
					st_reg <= H_TAR1;
				end
				H_TAR1: begin
					wcnt_reg <= 8'h00;
					st_reg <= H_WAIT;
				end
				H_WAIT: begin
					if (link.lad == lpc_pkg::SYNC_OK) begin
						ph_reg <= 1'b0;
						st_reg <= wr_reg ? H_ETAR : H_RD;
					end else if (wcnt_reg == 8'(SYNC_TMO)) begin
						// an ignored cycle never syncs, so end it with an abort
						lframe_reg <= 1'b0;
						out_reg <= lpc_pkg::NIB_ONES;
						oe_reg <= 1'b1;
						st_reg <= H_ABORT;
					end else begin
						wcnt_reg <= wcnt_reg + 8'h01;
					end
				end
				H_RD: begin
					ph_reg <= 1'b1;
					if (ph_reg) begin
						rdata[7:4] <= link.lad;
						st_reg <= H_ETAR;
					end else begin
						rdata[3:0] <= link.lad;
					end
				end
				H_ETAR: begin
					st_reg <= H_GAP;
				end
				H_GAP: begin
					// a status read is repeated until bit 6 matches the previous read on two re-reads in a row
					if (poll_reg && !(have_reg && stable_reg == 2'(lpc_pkg::POLL_STABLE))) begin
						again_reg <= 1'b1;
					end else begin
						done <= 1'b1;
						ok <= 1'b1;
						cmd_ready <= 1'b1;
					end
					st_reg <= H_IDLE;
				end
				H_ABORT: begin
					lframe_reg <= 1'b1;
					oe_reg <= 1'b0;
					done <= 1'b1;
					ok <= 1'b0;
					again_reg <= 1'b0;
					cmd_ready <= 1'b1;
					st_reg <= H_IDLE;
				end
				default: begin
					st_reg <= H_IDLE;
				end
			endcase
		end
	end

	// -------------------------------
	// poll stability tracking
	// -------------------------------
	logic prev6_reg;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			have_reg <= 1'b0;
			stable_reg <= 2'h0;
			prev6_reg <= 1'b0;
		end else if (st_reg == H_IDLE && cmd_valid && !again_reg) begin
			have_reg <= 1'b0;
			stable_reg <= 2'h0;
		end else if (st_reg == H_ETAR && poll_reg) begin
			have_reg <= 1'b1;
			prev6_reg <= rdata[6];
			if (have_reg && prev6_reg == rdata[6]) begin
				stable_reg <= stable_reg + 2'h1;
			end else begin
				stable_reg <= 2'h0;
			end
		end
	end
endmodule // lpc_flash_host
`default_nettype wire

// >>> lpc_flash_select_and_status_monitor.sv
/*
 wire checks for the flash link between the host end and the device end.
 assumes one clock, asynchronous active-low reset and a pulled-up link.
 */
`timescale 1ns/100ps
`default_nettype none
module lpc_flash_select_and_status_monitor (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// link
	input wire logic lframe_n,
	input wire logic [3:0] h_out,
	input wire logic h_oe,
	input wire logic [3:0] d_out,
	input wire logic d_oe,
	input wire logic [3:0] lad
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	// --------------------------------
	// assertions
	// --------------------------------
	a_one_driver: assert property (
		!(h_oe && d_oe)) else $error("both ends drive the link");
	a_start_code: assert property (
		!lframe_n |-> h_oe && (h_out == 4'h0 || h_out == 4'hd || h_out == 4'he || h_out == 4'hf))
		else $error("bad start nibble");
	a_frame_short: assert property (
		$fell(lframe_n) |=> lframe_n) else $error("frame strobe held too long");
	a_sync_zero: assert property (
		$rose(d_oe) |-> d_out == 4'h0 && lad == 4'h0) else $error("sync nibble not zero");
	a_turn_float: assert property (
		$rose(d_oe) |-> !$past(h_oe) && lframe_n) else $error("device took bus too early");
	a_dev_span: assert property (
		$rose(d_oe) |-> d_oe [*2] ##[1:3] !d_oe) else $error("device drive length wrong");
	a_dev_release: assert property (
		$fell(d_oe) |-> $past(lad) == 4'hf && !h_oe) else $error("device left bus badly");
	a_quiet_start: assert property (
		!lframe_n |-> !d_oe) else $error("device drives during start");
	a_abort_quiet: assert property (
		(!lframe_n && lad == 4'hf) |-> !$past(d_oe) && !$past(d_oe, 2) && !$past(d_oe, 3))
		else $error("device drove before abort");
	// --------------------------------
	// coverage
	// --------------------------------
	c_sync: cover property ($rose(d_oe));
	c_abort: cover property (!lframe_n && lad == 4'hf);
	c_fw_start: cover property (!lframe_n && lad == 4'hd);
endmodule // lpc_flash_select_and_status_monitor
`default_nettype wire

// >>> lpc_flash_select_and_status_test.sv
/*
 self-checking bench: host end and device end joined by the link.
 assumes the package defaults; settle window lengthened to see two reads in it.
 */
`timescale 1ns/100ps
`default_nettype none
module lpc_flash_select_and_status_test;
	typedef struct packed {
		logic [3:0] strap;
		logic fw;
		logic wr;
		logic [3:0] fw_device_select_field;
		logic [31:0] addr;
		logic [7:0] wdata;
		logic ok;
	} row_t;
	localparam int SETTLE = 40;
	localparam int TMO = 3000;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [3:0] strap = 4'h3;
	logic op_busy = 1'b0;
	logic op_erase = 1'b0;
	logic [7:0] op_data = 8'h00;
	logic [7:0] rd_data = 8'h00;
	logic cmd_valid = 1'b0;
	logic cmd_write = 1'b0;
	logic cmd_fw = 1'b0;
	logic cmd_poll = 1'b0;
	logic [3:0] cmd_fw_device_select_field = 4'h0;
	logic [31:0] cmd_addr = 32'h0;
	logic [7:0] cmd_wdata = 8'h00;
	logic cmd_ready, done, ok, acc_valid, acc_write, acc_array;
	logic [7:0] rdata, acc_wdata, prev;
	logic [18:0] acc_addr;
	int error_cnt = 0;
	int num_checks = 0;
	int cyc = 0;
	int acc_cnt = 0;
	int base;
	row_t rows [14] = '{
		'{4'h3, 1'b0, 1'b0, 4'h0, 32'hffe00012, 8'h00, 1'b1},
		'{4'h3, 1'b0, 1'b1, 4'h0, 32'hffa00034, 8'h77, 1'b1},
		'{4'he, 1'b0, 1'b0, 4'h0, 32'h000e0056, 8'h00, 1'b1},
		'{4'he, 1'b0, 1'b1, 4'h0, 32'h000fffff, 8'h5c, 1'b1},
		'{4'h3, 1'b0, 1'b0, 4'h0, 32'hffe80012, 8'h00, 1'b0},
		'{4'hc, 1'b0, 1'b0, 4'h0, 32'hffe00012, 8'h00, 1'b0},
		'{4'hd, 1'b0, 1'b0, 4'h0, 32'h00100000, 8'h00, 1'b0},
		'{4'he, 1'b0, 1'b0, 4'h0, 32'h000dffff, 8'h00, 1'b0},
		'{4'h0, 1'b0, 1'b0, 4'h0, 32'hfff80001, 8'h00, 1'b1},
		'{4'h3, 1'b1, 1'b0, 4'h3, 32'h00400078, 8'h00, 1'b1},
		'{4'h3, 1'b1, 1'b1, 4'h3, 32'h00000009, 8'hc3, 1'b1},
		'{4'h3, 1'b1, 1'b0, 4'hc, 32'h00400078, 8'h00, 1'b0},
		'{4'hf, 1'b1, 1'b0, 4'hf, 32'h0040007f, 8'h00, 1'b1},
		'{4'h0, 1'b1, 1'b0, 4'h0, 32'h00000011, 8'h00, 1'b1}};
	// --------------------------------
	// ends, link and monitor
	// --------------------------------
	lpc_link_if lpc_link_if_i();
	lpc_flash_dev #(.SETTLE_CYC(SETTLE)) lpc_flash_dev_i (.clk(clk), .arst_n(arst_n),
		.link(lpc_link_if_i), .select_strap_pins(strap), .op_busy(op_busy),
		.op_erase(op_erase), .op_data(op_data), .acc_valid(acc_valid), .acc_write(acc_write),
		.acc_array(acc_array), .acc_addr(acc_addr), .acc_wdata(acc_wdata), .rd_data(rd_data));
	lpc_flash_host lpc_flash_host_i (.clk(clk), .arst_n(arst_n), .link(lpc_link_if_i),
		.cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_fw(cmd_fw), .cmd_poll(cmd_poll),
		.cmd_fw_device_select_field(cmd_fw_device_select_field), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
		.cmd_ready(cmd_ready), .done(done), .ok(ok), .rdata(rdata));
	lpc_flash_select_and_status_monitor lpc_flash_select_and_status_monitor_i (.clk(clk),
		.arst_n(arst_n), .lframe_n(lpc_link_if_i.lframe_n), .h_out(lpc_link_if_i.h_out),
		.h_oe(lpc_link_if_i.h_oe), .d_out(lpc_link_if_i.d_out), .d_oe(lpc_link_if_i.d_oe),
		.lad(lpc_link_if_i.lad));
	// --------------------------------
	// clock, storage stand-in, timeout
	// --------------------------------
	initial begin
		forever #25 clk = ~clk;
	end
	// array and registers differ so a wrong steering bit shows in the data
	always @(negedge clk) begin
		rd_data <= acc_addr[7:0] ^ (acc_array ? 8'h5a : 8'ha5);
	end
	always @(posedge clk) begin
		if (acc_valid === 1'b1) acc_cnt <= acc_cnt + 1;
		cyc <= cyc + 1;
		if (cyc == TMO) begin
			error_cnt = error_cnt + 1;
			complete_run();
		end
	end
	// --------------------------------
	// tasks
	// --------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks = num_checks + 1;
		if (seen !== exp) begin
			error_cnt = error_cnt + 1;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic run(input logic fw, wr, poll, input logic [3:0] id,
			input logic [31:0] a, input logic [7:0] wd);
		@(negedge clk);
		while (cmd_ready !== 1'b1) @(negedge clk);
		cmd_fw = fw;
		cmd_write = wr;
		cmd_poll = poll;
		cmd_fw_device_select_field = id;
		cmd_addr = a;
		cmd_wdata = wd;
		cmd_valid = 1'b1;
		@(negedge clk);
		cmd_valid = 1'b0;
		while (done !== 1'b1) @(negedge clk);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// --------------------------------
	// sequence
	// --------------------------------
	initial begin
		repeat (2) @(posedge clk);
		#1;
		check({lpc_link_if_i.lframe_n, lpc_link_if_i.h_oe, lpc_link_if_i.d_oe}, 3'h4);
		check(cmd_ready, 1'b1);
		@(negedge clk);
		arst_n = 1'b1;
		foreach (rows[i]) begin
			strap = rows[i].strap;
			base = acc_cnt;
			run(rows[i].fw, rows[i].wr, 1'b0, rows[i].fw_device_select_field, rows[i].addr, rows[i].wdata);
			check(ok, rows[i].ok);
			check(acc_cnt - base, rows[i].ok);
			if (rows[i].ok) begin
				check(acc_array, rows[i].addr[22]);
				check({acc_write, acc_addr}, {rows[i].wr, rows[i].addr[18:0]});
				if (rows[i].wr) check(acc_wdata, rows[i].wdata);
				else check(rdata, rows[i].addr[7:0] ^ (rows[i].addr[22] ? 8'h5a : 8'ha5));
			end
			$display("row %0d ended", i);
		end
		// busy program, write refused, then erase
		strap = 4'h3;
		op_busy = 1'b1;
		op_data = 8'h00;
		run(1'b0, 1'b0, 1'b0, 4'h0, 32'hffe00012, 8'h00);
		check(rdata & 8'hbf, 8'h88);
		prev = rdata;
		base = acc_cnt;
		run(1'b0, 1'b1, 1'b0, 4'h0, 32'hffe00012, 8'h11);
		check({ok, 31'(acc_cnt - base)}, {1'b1, 31'h0});
		op_erase = 1'b1;
		run(1'b1, 1'b0, 1'b0, 4'h3, 32'h00400012, 8'h00);
		check(rdata[7:6], {1'b0, ~prev[6]});
		$display("busy test ended");
		// completion: status only, no toggling, then full data
		op_busy = 1'b0;
		run(1'b0, 1'b0, 1'b0, 4'h0, 32'hffe00012, 8'h00);
		check(rdata & 8'hbf, 8'h80);
		prev = rdata;
		run(1'b0, 1'b0, 1'b0, 4'h0, 32'hffe00012, 8'h00);
		check(rdata, prev);
		repeat (SETTLE) @(negedge clk);
		run(1'b0, 1'b0, 1'b0, 4'h0, 32'hffe00012, 8'h00);
		check(rdata, 8'h48);
		$display("completion test ended");
		// polling inside and outside the windows
		run(1'b0, 1'b0, 1'b1, 4'h0, 32'hffe00012, 8'h00);
		check({ok, rdata}, 9'h148);
		run(1'b0, 1'b0, 1'b1, 4'h0, 32'h12345678, 8'h00);
		check(ok, 1'b0);
		$display("poll test ended");
		// reset while the device drives the link, then a clean read
		@(negedge clk);
		cmd_write = 1'b0;
		cmd_fw = 1'b0;
		cmd_poll = 1'b0;
		cmd_addr = 32'hffe00012;
		cmd_valid = 1'b1;
		@(negedge clk);
		cmd_valid = 1'b0;
		repeat (12) @(negedge clk);
		check(lpc_link_if_i.d_oe, 1'b1);
		arst_n = 1'b0;
		#1;
		check({lpc_link_if_i.lframe_n, lpc_link_if_i.h_oe, lpc_link_if_i.d_oe}, 3'h4);
		check({cmd_ready, done, acc_valid}, 3'h4);
		@(negedge clk);
		arst_n = 1'b1;
		run(1'b0, 1'b0, 1'b0, 4'h0, 32'hffe00012, 8'h00);
		check({ok, rdata}, 9'h148);
		$display("reset test ended");
		complete_run();
	end
endmodule // lpc_flash_select_and_status_test
`default_nettype wire
